//--- pkg/rtih_pkg.sv
// Package: constants and carrier types of the pairing telegram framer
package rtih_pkg;

   // Value register layout
   localparam int VAL_W = 16;
   localparam int NUM_VALS = 7;
   localparam int ID_W = 32;
   localparam int PROF_W = 24;
   localparam int MAX_BYTES = 12;

   // Send option that arms one automatic pairing response
   localparam logic [3:0] SEND_OPT_PAIR_ONCE = 4'h4;

   // Telegram organisation codes
   localparam logic [7:0] ORG_PAIR = 8'hD4;
   localparam logic [7:0] ORG_VARLEN = 8'hD2;
   localparam logic [7:0] ORG_MAKER = 8'hD1;
   localparam logic [7:0] ORG_MBOX_EMPTY = 8'hF0;

   // Payload length limits
   localparam logic [15:0] MAX_LEN_PLAIN = 16'h000C;
   localparam logic [15:0] MAX_LEN_ADDR = 16'h0009;
   localparam logic [3:0] PAIR_LEN = 4'h7;
   localparam logic [3:0] SRC_ID_LAST = 4'h3;

   // First teach-in byte fields
   localparam int DIR_BIT = 7;
   localparam int RESP_BIT = 6;
   localparam int KIND_HI = 5;
   localparam int KIND_LO = 4;
   localparam logic [1:0] KIND_PAIR = 2'h0;
   localparam logic [1:0] KIND_DEL = 2'h1;
   localparam logic [1:0] KIND_ANY = 2'h2;
   localparam logic [1:0] KIND_UNUSED = 2'h3;
   localparam logic [3:0] PAIR_CMD_QUERY = 4'h0;
   localparam logic [3:0] PAIR_CMD_RESP = 4'h1;
   localparam logic [1:0] RES_ACCEPT = 2'h1;
   localparam logic [1:0] RES_DELETED = 2'h2;

   // Output buffer
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_W = 9;

   typedef enum logic [1:0] {TXK_PAIR = 2'h0, TXK_VARLEN = 2'h1, TXK_MAKER = 2'h2} rtih_txk_t;
   typedef enum logic {RXK_QUERY = 1'b0, RXK_POLL = 1'b1} rtih_rxk_t;

   typedef logic [NUM_VALS-1:0][VAL_W-1:0] rtih_values_t;

   // Host transmit request
   typedef struct packed {
      rtih_txk_t kind;
      logic addressed;
      rtih_values_t values;
   } rtih_host_tx_t;

   // Received radio event
   typedef struct packed {
      rtih_rxk_t kind;
      logic [ID_W-1:0] id;
      logic [7:0] db6;
      logic [7:0] chan;
      logic [10:0] mfr;
      logic [7:0] ptype;
      logic [7:0] pfunc;
      logic [7:0] prorg;
      logic acked;
      logic repeated;
   } rtih_rx_evt_t;

   // Telegram ready for serialising
   typedef struct packed {
      logic [7:0] org;
      logic [3:0] len;
      logic addressed;
      logic [ID_W-1:0] dst;
      logic [MAX_BYTES-1:0][7:0] data;
   } rtih_frame_t;

endpackage

//--- design/rtih_fifo.sv
// Synchronous valid/ready FIFO for the outgoing byte stream
`timescale 1ns/1ps
module rtih_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   // Honest full and empty
   assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem_q[rd_q];

   // Storage
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

//--- design/rtih_framer.sv
// Pairing telegram framer for one transmit channel, with mailbox
// Functional notes
// - Armed channel answers an incoming pairing query without further host action.
// - Send option 4 arms the channel; one query gets one pairing response.
// - Completed pairing loads partner id and profile code into channel registers.
// - Pairing loads are volatile until host rewrites channel with function 16.
// - Host-written pairing query or response is sent as a telegram.
// - First value bit 7 selects one-way (0) or two-way (1) operation.
// - First value bit 6 at 0 expects a response, at 1 does not.
// - Bits 5:4: pair, delete, unspecified; code 3 unused.
// - Second value holds the channel number to be paired.
// - Values 3-7: maker code low, high, profile type, function, organisation.
// - Mailbox holds message for acknowledged sensor; poll gets it or empty message.
// - Mailbox set up during pairing; repeated acknowledged sensors cannot pair.
// - Changing source identifier deletes the mailbox; pairing must be repeated.
// - First value gives payload length: at most 12, or 9 when addressed.
// - Payload bytes two per value, earlier byte in upper half.
`timescale 1ns/1ps
module rtih_framer (
   // Clock and reset
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   // Host channel configuration
   input wire logic ARM_WR_I,
   input wire logic [3:0] SEND_OPT_I,
   input wire logic SRC_ID_WR_I,
   input wire logic [rtih_pkg::ID_W-1:0] SRC_ID_I,
   input wire logic PERSIST_WR_I,
   input wire logic [rtih_pkg::ID_W-1:0] DEST_ID_I,
   input wire logic [rtih_pkg::PROF_W-1:0] PROF_I,
   // Host transmit request
   input wire logic TX_REQ_I,
   input wire rtih_pkg::rtih_host_tx_t TX_CMD_I,
   // Radio receive events
   input wire logic RX_VALID_I,
   input wire rtih_pkg::rtih_rx_evt_t RX_EVT_I,
   // Channel status
   output logic ARMED_O,
   output logic PAIRED_O,
   output logic VOLATILE_O,
   output logic [rtih_pkg::ID_W-1:0] DEST_ID_O,
   output logic [rtih_pkg::PROF_W-1:0] PROF_O,
   output logic MBOX_EN_O,
   output logic MBOX_FULL_O,
   output logic HOST_BUSY_O,
   output logic LEN_ERR_O,
   // Outgoing telegram byte stream
   output logic TX_VALID_O,
   input wire logic TX_READY_I,
   output logic [7:0] TX_DATA_O,
   output logic TX_LAST_O
);
   import rtih_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_HEAD = 3'b001,
      ST_DATA = 3'b011,
      ST_SRC = 3'b010,
      ST_DST = 3'b110
   } rtih_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // Frame builders

   // Automatic response to a received pairing query
   function automatic rtih_frame_t f_pair_resp(input rtih_rx_evt_t ev);
      rtih_frame_t f;
      f = '0;
      f.org = ORG_PAIR;
      f.len = PAIR_LEN;
      f.addressed = 1'b1;
      f.dst = ev.id;
      f.data[0] = {1'b1, 1'b1,
         (ev.db6[KIND_HI:KIND_LO] == KIND_DEL) ? RES_DELETED : RES_ACCEPT,
         PAIR_CMD_RESP};
      f.data[1] = ev.chan;
      f.data[2] = ev.mfr[7:0];
      f.data[3] = {5'h00, ev.mfr[10:8]};
      f.data[4] = ev.ptype;
      f.data[5] = ev.pfunc;
      f.data[6] = ev.prorg;
      return f;
   endfunction

   // Host frame from the seven value registers
   function automatic rtih_frame_t f_host(input rtih_host_tx_t c, input logic [ID_W-1:0] dst);
      rtih_frame_t f;
      f = '0;
      f.addressed = c.addressed;
      f.dst = dst;
      if (c.kind == TXK_PAIR) begin
         f.org = ORG_PAIR;
         f.len = PAIR_LEN;
         for (int i = 0; i < NUM_VALS; i++) begin
            f.data[i] = c.values[i][7:0];
         end
      end else begin
         f.org = (c.kind == TXK_MAKER) ? ORG_MAKER : ORG_VARLEN;
         f.len = c.values[0][3:0];
         for (int k = 0; k < MAX_BYTES / 2; k++) begin
            f.data[2*k] = c.values[1+k][15:8];
            f.data[2*k+1] = c.values[1+k][7:0];
         end
      end
      return f;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Event decode

   logic armed_q;
   logic paired_q;
   logic vol_q;
   logic [ID_W-1:0] dest_q;
   logic [PROF_W-1:0] prof_q;
   logic [ID_W-1:0] src_q;
   logic mbox_en_q;
   logic mbox_full_q;
   logic [ID_W-1:0] mbox_owner_q;
   rtih_frame_t mbox_frm_q;
   logic resp_pend_q;
   rtih_frame_t resp_frm_q;
   logic poll_pend_q;
   rtih_frame_t poll_frm_q;
   logic host_pend_q;
   rtih_frame_t host_frm_q;
   logic len_err_q;
   rtih_state_t st_q;
   rtih_frame_t cur_q;
   logic [3:0] cnt_q;

   logic is_query;
   logic query_ok;
   logic query_del;
   logic is_poll;
   logic src_change;
   logic len_bad;
   logic host_take;
   logic to_mbox;
   logic take_resp;
   logic take_poll;
   logic take_host;
   logic fifo_in_ready;
   logic push;
   logic last_byte;
   logic [7:0] byte_d;
   logic [FIFO_W-1:0] fifo_out;

   // Query acceptance: armed, legal kind, query command, no repeater for acked sensors
   assign is_query = RX_VALID_I && (RX_EVT_I.kind == RXK_QUERY);
   assign query_ok = is_query && armed_q
      && (RX_EVT_I.db6[KIND_HI:KIND_LO] != KIND_UNUSED)
      && (RX_EVT_I.db6[3:0] == PAIR_CMD_QUERY)
      && !(RX_EVT_I.acked && RX_EVT_I.repeated);
   assign query_del = RX_EVT_I.db6[KIND_HI:KIND_LO] == KIND_DEL;
   assign is_poll = RX_VALID_I && (RX_EVT_I.kind == RXK_POLL) && mbox_en_q
      && (RX_EVT_I.id == mbox_owner_q);
   assign src_change = SRC_ID_WR_I && (SRC_ID_I != src_q);

   // Host request checks
   assign len_bad = (TX_CMD_I.kind != TXK_PAIR)
      && (TX_CMD_I.values[0] > (TX_CMD_I.addressed ? MAX_LEN_ADDR : MAX_LEN_PLAIN));
   assign host_take = TX_REQ_I && !len_bad && !host_pend_q;
   assign to_mbox = host_take && mbox_en_q && (TX_CMD_I.kind != TXK_PAIR);

   // Arbitration at idle: response, then poll answer, then host
   assign take_resp = (st_q == ST_IDLE) && resp_pend_q;
   assign take_poll = (st_q == ST_IDLE) && !resp_pend_q && poll_pend_q;
   assign take_host = (st_q == ST_IDLE) && !resp_pend_q && !poll_pend_q && host_pend_q;

   ////////////////////////////////////////////////////////////////////////////
   // Channel registers

   // Arming for one automatic response
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         armed_q <= 1'b0;
      end else if (ARM_WR_I) begin
         armed_q <= (SEND_OPT_I == SEND_OPT_PAIR_ONCE);
      end else if (query_ok) begin
         armed_q <= 1'b0;
      end
   end

   // Target identifier and profile, volatile flag
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         paired_q <= 1'b0;
         vol_q <= 1'b0;
         dest_q <= '0;
         prof_q <= '0;
      end else if (query_ok) begin
         paired_q <= !query_del;
         vol_q <= 1'b1;
         dest_q <= RX_EVT_I.id;
         prof_q <= {RX_EVT_I.prorg, RX_EVT_I.pfunc, RX_EVT_I.ptype};
      end else if (PERSIST_WR_I) begin
         vol_q <= 1'b0;
         dest_q <= DEST_ID_I;
         prof_q <= PROF_I;
      end
   end

   // Source identifier used in every telegram
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         src_q <= '0;
      end else if (SRC_ID_WR_I) begin
         src_q <= SRC_ID_I;
      end
   end

   // Mailbox setup, deletion and content
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         mbox_en_q <= 1'b0;
         mbox_full_q <= 1'b0;
         mbox_owner_q <= '0;
         mbox_frm_q <= '0;
      end else if (query_ok && RX_EVT_I.acked) begin
         mbox_en_q <= !query_del;
         mbox_full_q <= 1'b0;
         mbox_owner_q <= RX_EVT_I.id;
      end else if (src_change) begin
         mbox_en_q <= 1'b0;
         mbox_full_q <= 1'b0;
      end else if (to_mbox) begin
         mbox_full_q <= 1'b1;
         mbox_frm_q <= f_host(TX_CMD_I, mbox_owner_q);
      end else if (is_poll) begin
         mbox_full_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pending telegrams (a new set wins over the take)

   // Automatic pairing response
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         resp_pend_q <= 1'b0;
         resp_frm_q <= '0;
      end else if (query_ok) begin
         resp_pend_q <= 1'b1;
         resp_frm_q <= f_pair_resp(RX_EVT_I);
      end else if (take_resp) begin
         resp_pend_q <= 1'b0;
      end
   end

   // Answer to a mailbox poll
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         poll_pend_q <= 1'b0;
         poll_frm_q <= '0;
      end else if (is_poll) begin
         poll_pend_q <= 1'b1;
         if (mbox_full_q) begin
            poll_frm_q <= mbox_frm_q;
         end else begin
            poll_frm_q <= '{org: ORG_MBOX_EMPTY, len: 4'h0, addressed: 1'b1,
               dst: mbox_owner_q, data: '0};
         end
      end else if (take_poll) begin
         poll_pend_q <= 1'b0;
      end
   end

   // Host telegram, refused while one is still waiting
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         host_pend_q <= 1'b0;
         host_frm_q <= '0;
      end else if (host_take && !to_mbox) begin
         host_pend_q <= 1'b1;
         host_frm_q <= f_host(TX_CMD_I, dest_q);
      end else if (take_host) begin
         host_pend_q <= 1'b0;
      end
   end

   // Length error pulse
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         len_err_q <= 1'b0;
      end else begin
         len_err_q <= TX_REQ_I && len_bad;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serialiser

   // Byte selection per state
   always_comb begin
      byte_d = cur_q.org;
      last_byte = 1'b0;
      unique case (st_q)
         ST_HEAD: begin
            byte_d = cur_q.org;
         end
         ST_DATA: begin
            byte_d = cur_q.data[cnt_q];
         end
         ST_SRC: begin
            byte_d = src_q[8*(3-cnt_q) +: 8];
            last_byte = (cnt_q == SRC_ID_LAST) && !cur_q.addressed;
         end
         ST_DST: begin
            byte_d = cur_q.dst[8*(3-cnt_q) +: 8];
            last_byte = (cnt_q == SRC_ID_LAST);
         end
         default: begin
            byte_d = cur_q.org;
         end
      endcase
   end

   assign push = (st_q != ST_IDLE) && fifo_in_ready;

   // Frame walk, stalled by the buffer
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         st_q <= ST_IDLE;
         cnt_q <= '0;
         cur_q <= '0;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               cnt_q <= '0;
               if (take_resp) begin
                  cur_q <= resp_frm_q;
                  st_q <= ST_HEAD;
               end else if (take_poll) begin
                  cur_q <= poll_frm_q;
                  st_q <= ST_HEAD;
               end else if (take_host) begin
                  cur_q <= host_frm_q;
                  st_q <= ST_HEAD;
               end
            end
            ST_HEAD: begin
               if (push) begin
                  st_q <= (cur_q.len == 4'h0) ? ST_SRC : ST_DATA;
               end
            end
            ST_DATA: begin
               if (push) begin
                  if (cnt_q == cur_q.len - 4'h1) begin
                     cnt_q <= '0;
                     st_q <= ST_SRC;
                  end else begin
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
            end
            ST_SRC: begin
               if (push) begin
                  cnt_q <= (cnt_q == SRC_ID_LAST) ? 4'h0 : cnt_q + 4'h1;
                  if (cnt_q == SRC_ID_LAST) begin
                     st_q <= cur_q.addressed ? ST_DST : ST_IDLE;
                  end
               end
            end
            ST_DST: begin
               if (push) begin
                  cnt_q <= (cnt_q == SRC_ID_LAST) ? 4'h0 : cnt_q + 4'h1;
                  if (cnt_q == SRC_ID_LAST) begin
                     st_q <= ST_IDLE;
                  end
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Output buffer
   rtih_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(CORE_CLK_I),
      .rst_i(RST_I),
      .in_valid_i(st_q != ST_IDLE),
      .in_ready_o(fifo_in_ready),
      .in_data_i({last_byte, byte_d}),
      .out_valid_o(TX_VALID_O),
      .out_ready_i(TX_READY_I),
      .out_data_o(fifo_out)
   );

   // Status outputs
   assign TX_DATA_O = fifo_out[7:0];
   assign TX_LAST_O = fifo_out[8];
   assign ARMED_O = armed_q;
   assign PAIRED_O = paired_q;
   assign VOLATILE_O = vol_q;
   assign DEST_ID_O = dest_q;
   assign PROF_O = prof_q;
   assign MBOX_EN_O = mbox_en_q;
   assign MBOX_FULL_O = mbox_full_q;
   assign HOST_BUSY_O = host_pend_q;
   assign LEN_ERR_O = len_err_q;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   property p_arm;
      @(posedge CORE_CLK_I) disable iff (RST_I)
      ARM_WR_I && (SEND_OPT_I == SEND_OPT_PAIR_ONCE) |=> armed_q;
   endproperty
   a_arm: assert property (p_arm) else $error("arm not taken");

   property p_auto_resp;
      @(posedge CORE_CLK_I) disable iff (RST_I)
      query_ok && !ARM_WR_I |=> resp_pend_q && !armed_q ##[1:40] (st_q == ST_HEAD);
   endproperty
   a_auto_resp: assert property (p_auto_resp) else $error("no response");

   property p_load_dest;
      @(posedge CORE_CLK_I) disable iff (RST_I)
      query_ok |=> (dest_q == $past(RX_EVT_I.id)) && vol_q;
   endproperty
   a_load_dest: assert property (p_load_dest) else $error("dest not loaded");

   property p_persist;
      @(posedge CORE_CLK_I) disable iff (RST_I)
      PERSIST_WR_I && !query_ok |=> !vol_q && (dest_q == $past(DEST_ID_I));
   endproperty
   a_persist: assert property (p_persist) else $error("persist failed");

   property p_resp_bits;
      @(posedge CORE_CLK_I) disable iff (RST_I)
      query_ok |=> resp_frm_q.data[0][DIR_BIT] && resp_frm_q.data[0][RESP_BIT]
         && (resp_frm_q.data[1] == $past(RX_EVT_I.chan));
   endproperty
   a_resp_bits: assert property (p_resp_bits) else $error("response bits");

   property p_unused_kind;
      @(posedge CORE_CLK_I) disable iff (RST_I)
      is_query && (RX_EVT_I.db6[KIND_HI:KIND_LO] == KIND_UNUSED) |-> !query_ok;
   endproperty
   a_unused_kind: assert property (p_unused_kind) else $error("unused kind");

   property p_src_del;
      @(posedge CORE_CLK_I) disable iff (RST_I)
      src_change && !(query_ok && RX_EVT_I.acked) |=> !mbox_en_q && !mbox_full_q;
   endproperty
   a_src_del: assert property (p_src_del) else $error("mailbox kept");

   property p_len;
      @(posedge CORE_CLK_I) disable iff (RST_I)
      TX_REQ_I && len_bad && !host_pend_q |=> LEN_ERR_O && !host_pend_q;
   endproperty
   a_len: assert property (p_len) else $error("length not refused");

   property p_pack;
      @(posedge CORE_CLK_I) disable iff (RST_I)
      host_take && !to_mbox && (TX_CMD_I.kind == TXK_VARLEN)
         |=> (host_frm_q.data[0] == $past(TX_CMD_I.values[1][15:8]))
         && (host_frm_q.data[1] == $past(TX_CMD_I.values[1][7:0]));
   endproperty
   a_pack: assert property (p_pack) else $error("packing wrong");

   property p_empty_mbox;
      @(posedge CORE_CLK_I) disable iff (RST_I)
      is_poll && !mbox_full_q && !query_ok |=> poll_pend_q
         && (poll_frm_q.org == ORG_MBOX_EMPTY);
   endproperty
   a_empty_mbox: assert property (p_empty_mbox) else $error("no empty answer");

   property p_repeater;
      @(posedge CORE_CLK_I) disable iff (RST_I)
      is_query && RX_EVT_I.acked && RX_EVT_I.repeated && !src_change |=> $stable(mbox_en_q);
   endproperty
   a_repeater: assert property (p_repeater) else $error("repeater paired");

   c_pair: cover property (@(posedge CORE_CLK_I) disable iff (RST_I) query_ok);
   c_poll: cover property (@(posedge CORE_CLK_I) disable iff (RST_I) is_poll && mbox_full_q);
   c_send: cover property (@(posedge CORE_CLK_I) disable iff (RST_I)
      TX_VALID_O && TX_READY_I && TX_LAST_O);
endmodule

//--- verif/rtih_radio_partner.sv
// Radio partner model: sends pairing queries and polls, and sinks the byte stream
`timescale 1ns/1ps
module rtih_radio_partner (
   // Clock and stall control
   input wire logic clk_i,
   input wire logic hold_i,
   // Radio events towards the framer
   output logic rx_valid_o,
   output rtih_pkg::rtih_rx_evt_t rx_evt_o,
   // Byte sink
   output logic tx_ready_o
);
   import rtih_pkg::*;
   integer seed = 32'h5C96F413;
   initial begin
      rx_valid_o = 1'b0;
      rx_evt_o = '0;
      tx_ready_o = 1'b0;
   end
   // Sink accepts at random, stalls fully while held
   always @(posedge clk_i) begin
      #1;
      tx_ready_o = !hold_i && (($random(seed) & 3) != 0);
   end
   // One event per call, bus scrambled once released
   task automatic send(input rtih_rx_evt_t e);
      @(posedge clk_i);
      #1;
      rx_valid_o = 1'b1;
      rx_evt_o = e;
      @(posedge clk_i);
      #1;
      rx_valid_o = 1'b0;
      rx_evt_o = ~e;
   endtask
endmodule

//--- verif/tb.sv
// Testbench: pairing framer against the radio partner model
`timescale 1ns/1ps
module tb;
   import rtih_pkg::*;
   logic clk = 0, rst = 1, arm = 0, sidw = 0, pw = 0, req = 0, hold = 0;
   logic [3:0] opt = '0;
   logic [31:0] sid = '0, did = '0, dsto;
   logic [23:0] prof = '0, profo;
   rtih_host_tx_t cmd = '0;
   rtih_rx_evt_t ev, rxe;
   logic rxv, rdy, armed, paired, vol, mben, mbfull, busy, lerr, txv, txl;
   logic [7:0] txd;
   logic [8:0] e;
   logic [8:0] q[$];
   int errors = 0, n_tests = 0, cyc = 0;
   integer seed = 32'h5C96F413;

   rtih_framer dut_u (.CORE_CLK_I(clk), .RST_I(rst), .ARM_WR_I(arm), .SEND_OPT_I(opt),
      .SRC_ID_WR_I(sidw), .SRC_ID_I(sid), .PERSIST_WR_I(pw), .DEST_ID_I(did), .PROF_I(prof),
      .TX_REQ_I(req), .TX_CMD_I(cmd), .RX_VALID_I(rxv), .RX_EVT_I(rxe), .ARMED_O(armed),
      .PAIRED_O(paired), .VOLATILE_O(vol), .DEST_ID_O(dsto), .PROF_O(profo), .MBOX_EN_O(mben),
      .MBOX_FULL_O(mbfull), .HOST_BUSY_O(busy), .LEN_ERR_O(lerr), .TX_VALID_O(txv),
      .TX_READY_I(rdy), .TX_DATA_O(txd), .TX_LAST_O(txl));
   rtih_radio_partner partner_u (.clk_i(clk), .hold_i(hold), .rx_valid_o(rxv),
      .rx_evt_o(rxe), .tx_ready_o(rdy));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock
   initial forever #5 clk = ~clk;

   task automatic report_and_stop;
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic fail(input logic [31:0] g, input logic [31:0] x);
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      n_tests++;
      if (g !== x) fail(g, x);
   endtask
   task automatic tick;
      @(posedge clk);
      #1;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick();
      s = 1'b0;
   endtask
   task automatic ex(input logic [7:0] b, input logic l);
      q.push_back({l, b});
   endtask
   task automatic ex_id(input logic [31:0] v, input logic l);
      for (int i = 3; i >= 0; i--) ex(v[8*i+:8], l && i == 0);
   endtask
   // Bounded wait until every noted byte has been seen
   task automatic drain;
      for (int i = 0; i < 400 && q.size() != 0; i++) tick();
      if (q.size() != 0) fail(q.size(), 0);
      repeat (4) tick();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Pairing query from a partner, with the expected response noted first
   task automatic pair(input logic [1:0] k, input logic ak, input logic rp);
      logic [95:0] r;
      logic ok;
      r = {$random(seed), $random(seed), $random(seed)};
      ev = r[85:0];
      ev.kind = RXK_QUERY;
      ev.db6 = {1'b1, 1'b0, k, 4'h0};
      ev.acked = ak;
      ev.repeated = rp;
      ok = k != KIND_UNUSED && !(ak && rp);
      if (ok) begin
         ex(ORG_PAIR, 0);
         ex({2'b11, k == KIND_DEL ? RES_DELETED : RES_ACCEPT, PAIR_CMD_RESP}, 0);
         ex(ev.chan, 0);
         ex(ev.mfr[7:0], 0);
         ex({5'h00, ev.mfr[10:8]}, 0);
         ex(ev.ptype, 0);
         ex(ev.pfunc, 0);
         ex(ev.prorg, 0);
         ex_id(sid, 0);
         ex_id(ev.id, 1);
      end
      partner_u.send(ev);
      if (!ok) chk(armed, 1);
      else begin
         chk(armed, 0);
         chk(dsto, ev.id);
         chk(profo, {ev.prorg, ev.pfunc, ev.ptype});
         chk(paired, k != KIND_DEL);
         chk(vol, 1);
         chk(mben, ak && k != KIND_DEL);
      end
      drain();
   endtask

   // Host transmit request, expected frame noted first
   task automatic host(input rtih_txk_t k, input logic a, input logic [3:0] n);
      logic [7:0] b;
      for (int i = 0; i < NUM_VALS; i++) cmd.values[i] = 16'($random(seed));
      cmd.kind = k;
      cmd.addressed = a;
      if (k != TXK_PAIR) cmd.values[0] = {12'h000, n};
      ex(k == TXK_PAIR ? ORG_PAIR : k == TXK_VARLEN ? ORG_VARLEN : ORG_MAKER, 0);
      for (int i = 0; i < n; i++) begin
         b = k == TXK_PAIR ? cmd.values[i][7:0] : cmd.values[1+i/2][i[0] ? 7 : 15 -: 8];
         ex(b, 0);
      end
      ex_id(sid, !a);
      if (a) ex_id(dsto, 1);
      pulse(req);
      chk(mben ? mbfull : busy, 1);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Stream monitor and hang limit
   always @(posedge clk) begin
      cyc++;
      if (!rst && txv === 1'b1 && rdy === 1'b1) begin
         n_tests++;
         e = q.size() != 0 ? q.pop_front() : 'x;
         if ({txl, txd} !== e) fail({txl, txd}, e);
      end
      if (cyc > 20000) begin
         errors++;
         report_and_stop();
      end
   end

   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      #1;
      rst = 1'b0;
      chk({armed, paired, vol, mben, mbfull, busy, txv}, 0);
      sid = $random(seed);
      pulse(sidw);
      opt = SEND_OPT_PAIR_ONCE;
      for (int k = 0; k < 4; k++) begin
         pulse(arm);
         chk(armed, 1);
         pair(2'(k), 1'b0, 1'b0);
      end
      opt = 4'h0;
      pulse(arm);
      chk(armed, 0);
      did = $random(seed);
      prof = 24'($random(seed));
      pulse(pw);
      chk({vol, dsto, profo}, {1'b0, did, prof});
      hold = 1'b1;
      host(TXK_MAKER, 1'b0, 4'hC);
      repeat (30) tick();
      chk(txv, 1);
      hold = 1'b0;
      drain();
      host(TXK_VARLEN, 1'b1, 4'h9);
      drain();
      host(TXK_PAIR, 1'b0, PAIR_LEN);
      drain();
      cmd.kind = TXK_VARLEN;
      cmd.addressed = 1'b1;
      cmd.values[0] = 16'h000A;
      pulse(req);
      chk({lerr, busy}, 2'b10);
      opt = SEND_OPT_PAIR_ONCE;
      pulse(arm);
      pair(KIND_PAIR, 1'b1, 1'b1);
      pair(KIND_PAIR, 1'b1, 1'b0);
      host(TXK_MAKER, 1'b0, 4'h3);
      repeat (20) tick();
      chk(txv, 0);
      ev.kind = RXK_POLL;
      partner_u.send(ev);
      chk(mbfull, 0);
      drain();
      ex(ORG_MBOX_EMPTY, 0);
      ex_id(sid, 0);
      ex_id(ev.id, 1);
      partner_u.send(ev);
      drain();
      sid = ~sid;
      pulse(sidw);
      chk(mben, 0);
      report_and_stop();
   end
endmodule
